// ---- ssr_pkg.sv ----
// Purpose: Shared constants and helpers for the status byte and service request block.
// Assumes: One 10 MHz clock and a synchronous active-high reset that stands for power-on.
// Notes: Bit positions follow the status byte and standard event register layouts.
package ssr_pkg;

  localparam int REG_W = 8;

  // Status summary byte bit positions.
  localparam int SSB_ERR_BIT = 7;
  localparam int SSB_REQ_BIT = 6;
  localparam int SSB_EVT_BIT = 5;
  localparam int SSB_MSG_BIT = 4;
  localparam int SSB_DEV_BIT = 3;

  // Standard event flag bit positions.
  localparam int SEF_PWR_BIT = 7;
  localparam int SEF_USER_BIT = 6;
  localparam int SEF_CMDF_BIT = 5;
  localparam int SEF_EXEF_BIT = 4;
  localparam int SEF_DEVF_BIT = 3;
  localparam int SEF_QRYF_BIT = 2;
  localparam int SEF_CTRL_BIT = 1;
  localparam int SEF_DONE_BIT = 0;

  // Reset values.
  localparam logic [REG_W-1:0] SEF_RESET = 8'h80;
  localparam logic [REG_W-1:0] MASK_RESET = 8'h00;
  localparam logic [REG_W-1:0] ZERO_BYTE = 8'h00;

  // Bits that can be set in each register.
  localparam logic [REG_W-1:0] SSB_USED = 8'hB8;
  localparam logic [REG_W-1:0] SEF_USED = 8'hBD;

  // Answer source selection for the response register.
  typedef enum logic [2:0] {
    RSP_POLL = 3'b000,
    RSP_SSB = 3'b001,
    RSP_ESR = 3'b010,
    RSP_SRE = 3'b011,
    RSP_ESE = 3'b100
  } ssr_rsp_t;

  // True when any bit survives the mask.
  function automatic logic masked_any(input logic [REG_W-1:0] bits,
                                      input logic [REG_W-1:0] mask);
    masked_any = |(bits & mask);
  endfunction : masked_any

endpackage : ssr_pkg

// ---- ssr_evt_if.sv ----
// Purpose: Carries event sets, clears and summary between the core and the event register.
// Assumes: Both ends run on the same clock.
// Notes: Sets are one-cycle pulses per bit; clear is a one-cycle pulse.
`timescale 1ns/1ns
interface ssr_evt_if;
  logic [ssr_pkg::REG_W-1:0] sets;
  logic clear;
  logic [ssr_pkg::REG_W-1:0] mask;
  logic [ssr_pkg::REG_W-1:0] flags;
  logic summary;

  modport core (output sets, output clear, output mask, input flags, input summary);
  modport evreg (input sets, input clear, input mask, output flags, output summary);
endinterface : ssr_evt_if

// ---- ssr_event_reg.sv ----
// Purpose: Standard event flag register with its summary bit.
// Assumes: Reset is power-on.
// Notes: A set arriving with a clear wins, so no event is lost.
`timescale 1ns/1ns
module ssr_event_reg (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Link to the core.
  ssr_evt_if.evreg ev
);

  logic [ssr_pkg::REG_W-1:0] flags_ff;
  logic [ssr_pkg::REG_W-1:0] nxt_flags;

  always_comb begin
    nxt_flags = flags_ff;
    if (ev.clear) begin
      nxt_flags = ssr_pkg::ZERO_BYTE;
    end
    // Unused bits never latch.
    nxt_flags = (nxt_flags | ev.sets) & ssr_pkg::SEF_USED;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      flags_ff <= ssr_pkg::SEF_RESET;
    end else begin
      flags_ff <= nxt_flags;
    end
  end

  assign ev.flags = flags_ff;
  assign ev.summary = ssr_pkg::masked_any(flags_ff, ev.mask);

endmodule : ssr_event_reg

// ---- ssr_status_core.sv ----
// Purpose: Status summary byte, service request and standard event handling.
// Assumes: Command strobes come from a same-clock message decoder, one at a time.
// Notes: SYS_RST stands for power-on; the serial-link select is a pin and is synchronised.
`timescale 1ns/1ns
module ssr_status_core (
  // Clock and reset.
  input wire logic CLK,
  input wire logic SYS_RST,
  // Link selection pin, high while the serial link is in use.
  input wire logic SERIAL_LINK_SEL,
  // Command strobes from the message decoder.
  input wire logic CMD_SERIAL_POLL,
  input wire logic CMD_SSB_QUERY,
  input wire logic CMD_ESR_QUERY,
  input wire logic CMD_SRE_QUERY,
  input wire logic CMD_ESE_QUERY,
  input wire logic CMD_CLEAR_STATUS,
  input wire logic CMD_SRE_WRITE,
  input wire logic CMD_ESE_WRITE,
  input wire logic CMD_OP_DONE,
  input wire logic [ssr_pkg::REG_W-1:0] CMD_DATA,
  // Event sources.
  input wire logic EV_CMD_FAULT,
  input wire logic EV_EXEC_FAULT,
  input wire logic EV_DEVICE_FAULT,
  input wire logic EV_QUERY_FAULT,
  input wire logic EV_POWER_RESTORED,
  input wire logic PRIOR_MSGS_DONE,
  // Status levels.
  input wire logic OUTQ_NOT_EMPTY,
  input wire logic DEVICE_EVENT_SUMMARY,
  input wire logic UNRECOVERABLE_ERR,
  // Answers and controls.
  output logic RSP_VALID,
  output logic [ssr_pkg::REG_W-1:0] RSP_DATA,
  output logic SERVICE_REQUEST,
  output logic OUTQ_CLEAR,
  output logic CMD_DISCARD
);

  ssr_evt_if ev ();

  ssr_event_reg u_event_reg (
    .clk(CLK),
    .rst(SYS_RST),
    .ev(ev.evreg)
  );

  // Synchroniser for the serial-link pin.
  logic serial_meta_ff;
  logic serial_sync_ff;

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      serial_meta_ff <= 1'b0;
      serial_sync_ff <= 1'b0;
    end else begin
      serial_meta_ff <= SERIAL_LINK_SEL;
      serial_sync_ff <= serial_meta_ff;
    end
  end

  // Mask registers.
  logic [ssr_pkg::REG_W-1:0] service_request_mask_ff;
  logic [ssr_pkg::REG_W-1:0] standard_event_mask_ff;

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      service_request_mask_ff <= ssr_pkg::MASK_RESET;
    end else if (CMD_SRE_WRITE) begin
      service_request_mask_ff <= CMD_DATA;
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      standard_event_mask_ff <= ssr_pkg::MASK_RESET;
    end else if (CMD_ESE_WRITE) begin
      standard_event_mask_ff <= CMD_DATA;
    end
  end

  assign ev.mask = standard_event_mask_ff;

  // Operation-complete tracking: the flag waits until earlier messages finish.
  logic done_pending_ff;
  logic done_fire;

  assign done_fire = (done_pending_ff | CMD_OP_DONE) & PRIOR_MSGS_DONE;

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      done_pending_ff <= 1'b0;
    end else if (done_fire) begin
      done_pending_ff <= 1'b0;
    end else if (CMD_OP_DONE) begin
      done_pending_ff <= 1'b1;
    end
  end

  // Event set pulses into the standard event flags.
  logic [ssr_pkg::REG_W-1:0] nxt_sets;

  always_comb begin
    nxt_sets = ssr_pkg::ZERO_BYTE;
    nxt_sets[ssr_pkg::SEF_PWR_BIT] = EV_POWER_RESTORED;
    nxt_sets[ssr_pkg::SEF_CMDF_BIT] = EV_CMD_FAULT;
    nxt_sets[ssr_pkg::SEF_EXEF_BIT] = EV_EXEC_FAULT;
    nxt_sets[ssr_pkg::SEF_DEVF_BIT] = EV_DEVICE_FAULT;
    nxt_sets[ssr_pkg::SEF_QRYF_BIT] = EV_QUERY_FAULT;
    nxt_sets[ssr_pkg::SEF_DONE_BIT] = done_fire;
  end

  assign ev.sets = nxt_sets;
  // The flags are cleared by the clear command and by reading them.
  assign ev.clear = CMD_CLEAR_STATUS | CMD_ESR_QUERY;

  // Side effects of faults towards the message path.
  logic outq_clear_ff;
  logic cmd_discard_ff;

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      outq_clear_ff <= 1'b0;
    end else begin
      outq_clear_ff <= EV_QUERY_FAULT;
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      cmd_discard_ff <= 1'b0;
    end else begin
      cmd_discard_ff <= EV_CMD_FAULT;
    end
  end

  assign OUTQ_CLEAR = outq_clear_ff;
  assign CMD_DISCARD = cmd_discard_ff;

  // Status summary byte without bit 6.
  logic [ssr_pkg::REG_W-1:0] ssb_bits;

  always_comb begin
    ssb_bits = ssr_pkg::ZERO_BYTE;
    ssb_bits[ssr_pkg::SSB_ERR_BIT] = UNRECOVERABLE_ERR;
    ssb_bits[ssr_pkg::SSB_EVT_BIT] = ev.summary;
    // Message available is suppressed on the serial link.
    ssb_bits[ssr_pkg::SSB_MSG_BIT] = OUTQ_NOT_EMPTY & ~serial_sync_ff;
    ssb_bits[ssr_pkg::SSB_DEV_BIT] = DEVICE_EVENT_SUMMARY;
  end

  // Master summary and request detection.
  logic [ssr_pkg::REG_W-1:0] enabled_bits;
  logic [ssr_pkg::REG_W-1:0] enabled_prev_ff;
  logic master_summary_bit;
  logic request_rise;

  assign enabled_bits = ssb_bits & service_request_mask_ff & ssr_pkg::SSB_USED;
  // Bit 6 of the mask is ignored because SSB_USED excludes it.
  assign master_summary_bit = ssr_pkg::masked_any(ssb_bits,
                                                  service_request_mask_ff & ssr_pkg::SSB_USED);
  assign request_rise = |(enabled_bits & ~enabled_prev_ff);

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      enabled_prev_ff <= ssr_pkg::ZERO_BYTE;
    end else begin
      enabled_prev_ff <= enabled_bits;
    end
  end

  // Request-service bit, which is also the service request line.
  logic request_service_bit_ff;

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      request_service_bit_ff <= 1'b0;
    end else if (request_rise) begin
      request_service_bit_ff <= 1'b1;
    end else if (CMD_SERIAL_POLL | CMD_CLEAR_STATUS) begin
      request_service_bit_ff <= 1'b0;
    end
  end

  assign SERVICE_REQUEST = request_service_bit_ff;

  // Answer selection.
  logic rsp_req;
  ssr_pkg::ssr_rsp_t rsp_sel;

  assign rsp_req = CMD_SERIAL_POLL | CMD_SSB_QUERY | CMD_ESR_QUERY |
                   CMD_SRE_QUERY | CMD_ESE_QUERY;

  always_comb begin
    if (CMD_SERIAL_POLL) begin
      rsp_sel = ssr_pkg::RSP_POLL;
    end else if (CMD_SSB_QUERY) begin
      rsp_sel = ssr_pkg::RSP_SSB;
    end else if (CMD_ESR_QUERY) begin
      rsp_sel = ssr_pkg::RSP_ESR;
    end else if (CMD_SRE_QUERY) begin
      rsp_sel = ssr_pkg::RSP_SRE;
    end else begin
      rsp_sel = ssr_pkg::RSP_ESE;
    end
  end

  logic [ssr_pkg::REG_W-1:0] nxt_rsp_data;

  always_comb begin
    nxt_rsp_data = ssb_bits;
    case (rsp_sel)
      ssr_pkg::RSP_POLL: begin
        // Poll returns the request bit as it stands before it is cleared.
        nxt_rsp_data[ssr_pkg::SSB_REQ_BIT] = request_service_bit_ff;
      end
      ssr_pkg::RSP_SSB: begin
        nxt_rsp_data[ssr_pkg::SSB_REQ_BIT] = master_summary_bit;
      end
      ssr_pkg::RSP_ESR: begin
        nxt_rsp_data = ev.flags;
      end
      ssr_pkg::RSP_SRE: begin
        nxt_rsp_data = service_request_mask_ff;
      end
      default: begin
        nxt_rsp_data = standard_event_mask_ff;
      end
    endcase
  end

  logic rsp_valid_ff;
  logic [ssr_pkg::REG_W-1:0] rsp_data_ff;

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      rsp_valid_ff <= 1'b0;
    end else begin
      rsp_valid_ff <= rsp_req;
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      rsp_data_ff <= ssr_pkg::ZERO_BYTE;
    end else if (rsp_req) begin
      rsp_data_ff <= nxt_rsp_data;
    end
  end

  assign RSP_VALID = rsp_valid_ff;
  assign RSP_DATA = rsp_data_ff;

endmodule : ssr_status_core

// ---- ssr_status_assertions.sv ----
// Purpose: Port-level checks of the status byte and service request block.
// Assumes: One clock; reset high means power-on.
// Notes: Bound to every instance of the core.
`timescale 1ns/1ns
module ssr_status_assertions (
  // Clock and reset.
  input wire logic CLK,
  input wire logic SYS_RST,
  // Commands and events.
  input wire logic SERIAL_LINK_SEL,
  input wire logic CMD_SERIAL_POLL,
  input wire logic CMD_SSB_QUERY,
  input wire logic CMD_ESR_QUERY,
  input wire logic CMD_SRE_QUERY,
  input wire logic CMD_ESE_QUERY,
  input wire logic CMD_CLEAR_STATUS,
  input wire logic EV_CMD_FAULT,
  input wire logic EV_QUERY_FAULT,
  // Status levels.
  input wire logic OUTQ_NOT_EMPTY,
  input wire logic DEVICE_EVENT_SUMMARY,
  input wire logic UNRECOVERABLE_ERR,
  // Outputs.
  input wire logic RSP_VALID,
  input wire logic [ssr_pkg::REG_W-1:0] RSP_DATA,
  input wire logic SERVICE_REQUEST,
  input wire logic OUTQ_CLEAR,
  input wire logic CMD_DISCARD
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  logic any_q;
  assign any_q = CMD_SERIAL_POLL | CMD_SSB_QUERY | CMD_ESR_QUERY | CMD_SRE_QUERY | CMD_ESE_QUERY;
  sequence s_status_read;
    CMD_SERIAL_POLL || CMD_SSB_QUERY;
  endsequence
  a_answer_timing: assert property (any_q |=> RSP_VALID)
    else $error("answer missing after a query");
  a_answer_cause: assert property (RSP_VALID |-> $past(any_q))
    else $error("answer without a query");
  a_poll_request: assert property (CMD_SERIAL_POLL |=> RSP_DATA[6] == $past(SERVICE_REQUEST))
    else $error("poll byte does not carry the request");
  a_request_holds: assert property (SERVICE_REQUEST && !CMD_SERIAL_POLL && !CMD_CLEAR_STATUS
    |=> SERVICE_REQUEST)
    else $error("request dropped without poll or clear");
  a_status_fixed: assert property (s_status_read |=> RSP_DATA[2:0] == 3'h0 &&
    RSP_DATA[7] == $past(UNRECOVERABLE_ERR) && RSP_DATA[3] == $past(DEVICE_EVENT_SUMMARY))
    else $error("status byte fixed bits wrong");
  a_serial_nomsg: assert property (SERIAL_LINK_SEL [*3] ##0 s_status_read |=> !RSP_DATA[4])
    else $error("message bit set on serial link");
  a_msg_avail: assert property (!SERIAL_LINK_SEL [*3] ##0 s_status_read
    |=> RSP_DATA[4] == $past(OUTQ_NOT_EMPTY))
    else $error("message bit does not follow the queue");
  a_cmd_discard: assert property (EV_CMD_FAULT |=> CMD_DISCARD)
    else $error("command fault did not discard");
  a_queue_clear: assert property (EV_QUERY_FAULT |=> OUTQ_CLEAR)
    else $error("query fault did not clear the queue");
  a_reset_quiet: assert property (disable iff (1'b0) SYS_RST
    |=> !RSP_VALID && !SERVICE_REQUEST && !OUTQ_CLEAR && !CMD_DISCARD)
    else $error("outputs active after power-on");
endmodule : ssr_status_assertions

bind ssr_status_core ssr_status_assertions i_ssr_status_assertions (.CLK(CLK), .SYS_RST(SYS_RST),
  .SERIAL_LINK_SEL(SERIAL_LINK_SEL), .CMD_SERIAL_POLL(CMD_SERIAL_POLL),
  .CMD_SSB_QUERY(CMD_SSB_QUERY), .CMD_ESR_QUERY(CMD_ESR_QUERY), .CMD_SRE_QUERY(CMD_SRE_QUERY),
  .CMD_ESE_QUERY(CMD_ESE_QUERY), .CMD_CLEAR_STATUS(CMD_CLEAR_STATUS),
  .EV_CMD_FAULT(EV_CMD_FAULT), .EV_QUERY_FAULT(EV_QUERY_FAULT), .OUTQ_NOT_EMPTY(OUTQ_NOT_EMPTY),
  .DEVICE_EVENT_SUMMARY(DEVICE_EVENT_SUMMARY), .UNRECOVERABLE_ERR(UNRECOVERABLE_ERR),
  .RSP_VALID(RSP_VALID), .RSP_DATA(RSP_DATA), .SERVICE_REQUEST(SERVICE_REQUEST),
  .OUTQ_CLEAR(OUTQ_CLEAR), .CMD_DISCARD(CMD_DISCARD));

// ---- ssr_outq_model.sv ----
// Purpose: Output queue on the controller side of the block.
// Assumes: Same clock as the core.
// Notes: Holds one message flag; a clear request empties it.
`timescale 1ns/1ns
module ssr_outq_model (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Queue control.
  input wire logic put,
  input wire logic clear,
  output logic not_empty
);
  always_ff @(posedge clk) begin
    if (rst || clear) begin
      not_empty <= 1'b0;
    end else if (put) begin
      not_empty <= 1'b1;
    end
  end
endmodule : ssr_outq_model

// ---- tb_top.sv ----
// Purpose: Self-checking bench for the status byte and service request block.
// Assumes: Inputs change at the falling edge.
// Notes: Expected answers are queued and compared when an answer appears.
`timescale 1ns/1ns
module tb_top;
  logic clk = 1'b0, rst = 1'b1, ser = 1'b0, done = 1'b1, put = 1'b0, err = 1'b0, device_event_summary_bit = 1'b0;
  logic clr = 1'b0, sw = 1'b0, ew = 1'b0, opd = 1'b0;
  logic [4:0] cmd = 5'h00, ev = 5'h00;
  logic [7:0] d = 8'h00, m;
  logic [7:0] evb [5] = '{8'h20, 8'h10, 8'h08, 8'h04, 8'h80};
  logic rv, sr, oc, outq, cd;
  logic [7:0] rd;
  logic [7:0] exq [$];
  int fail_count = 0, checked = 0;
  initial forever #50 clk = ~clk;
  ssr_status_core i_ssr_status_core (.CLK(clk), .SYS_RST(rst), .SERIAL_LINK_SEL(ser),
    .CMD_SERIAL_POLL(cmd[0]), .CMD_SSB_QUERY(cmd[1]), .CMD_ESR_QUERY(cmd[2]),
    .CMD_SRE_QUERY(cmd[3]), .CMD_ESE_QUERY(cmd[4]), .CMD_CLEAR_STATUS(clr),
    .CMD_SRE_WRITE(sw), .CMD_ESE_WRITE(ew), .CMD_OP_DONE(opd), .CMD_DATA(d),
    .EV_CMD_FAULT(ev[0]), .EV_EXEC_FAULT(ev[1]), .EV_DEVICE_FAULT(ev[2]),
    .EV_QUERY_FAULT(ev[3]), .EV_POWER_RESTORED(ev[4]), .PRIOR_MSGS_DONE(done),
    .OUTQ_NOT_EMPTY(outq), .DEVICE_EVENT_SUMMARY(device_event_summary_bit), .UNRECOVERABLE_ERR(err),
    .RSP_VALID(rv), .RSP_DATA(rd), .SERVICE_REQUEST(sr), .OUTQ_CLEAR(oc), .CMD_DISCARD(cd));
  ssr_outq_model i_ssr_outq_model (.clk(clk), .rst(rst), .put(put), .clear(oc),
    .not_empty(outq));
  task tick(input int n);
    repeat (n) @(negedge clk);
  endtask : tick
  task chk(input logic [7:0] e, input logic [7:0] s, input string n);
    checked++;
    if (s !== e) begin
      $display("MISMATCH %s expected %h seen %h", n, e, s);
      fail_count++;
    end
  endtask : chk
  task ask(input int k, input logic [7:0] e);
    cmd[k] = 1'b1;
    exq.push_back(e);
    tick(1);
    cmd[k] = 1'b0;
    tick(2);
  endtask : ask
  task hit(input int k);
    ev[k] = 1'b1;
    tick(1);
    ev[k] = 1'b0;
    chk({7'h00, 1'(k == 0)}, {7'h00, cd}, "discard");
    tick(2);
  endtask : hit
  task wr(input logic e, input logic [7:0] v);
    d = v;
    ew = e;
    sw = ~e;
    tick(1);
    ew = 1'b0;
    sw = 1'b0;
    tick(1);
  endtask : wr
  task cls;
    clr = 1'b1;
    tick(1);
    clr = 1'b0;
    tick(1);
  endtask : cls
  // Status byte as the bench expects it from its own levels.
  function automatic logic [7:0] sb(input logic b6, input logic b5);
    sb = {err, b6, b5, outq & ~ser, device_event_summary_bit, 3'h0};
  endfunction : sb
  task stop_test;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : stop_test
  always @(negedge clk) begin
    if (rv === 1'b1) begin
      if (exq.size() > 0) begin
        chk(exq.pop_front(), rd, "answer");
      end else begin
        $display("MISMATCH answer expected none seen %h", rd);
        fail_count++;
      end
    end
  end
  initial begin
    #400000;
    fail_count++;
    stop_test();
  end
  initial begin
    void'($urandom(32'h8DDA));
    tick(20);
    rst = 1'b0;
    err = 1'($urandom);
    device_event_summary_bit = 1'($urandom);
    tick(1);
    ask(2, ssr_pkg::SEF_RESET);
    ask(2, 8'h00);
    ask(3, ssr_pkg::MASK_RESET);
    ask(4, ssr_pkg::MASK_RESET);
    for (int i = 0; i < 5; i++) begin
      hit(i);
      ask(2, evb[i]);
    end
    done = 1'b0;
    opd = 1'b1;
    tick(1);
    opd = 1'b0;
    tick(1);
    ask(2, 8'h00);
    done = 1'b1;
    tick(2);
    ask(2, 8'h01);
    m = 8'($urandom);
    wr(1'b0, m);
    ask(3, m);
    wr(1'b1, ~m);
    ask(4, ~m);
    wr(1'b0, 8'h20);
    wr(1'b1, 8'h20);
    cls();
    hit(0);
    chk(8'h01, {7'h00, sr}, "request");
    ask(1, sb(1'b1, 1'b1));
    ask(0, sb(1'b1, 1'b1));
    chk(8'h00, {7'h00, sr}, "request");
    ask(1, sb(1'b1, 1'b1));
    cls();
    ask(1, sb(1'b0, 1'b0));
    wr(1'b0, 8'h00);
    wr(1'b1, 8'h10);
    hit(1);
    chk(8'h00, {7'h00, sr}, "request");
    ask(1, sb(1'b0, 1'b1));
    wr(1'b1, 8'h00);
    ask(1, sb(1'b0, 1'b0));
    put = 1'b1;
    tick(1);
    put = 1'b0;
    tick(1);
    ask(1, sb(1'b0, 1'b0));
    ser = 1'b1;
    tick(3);
    ask(1, sb(1'b0, 1'b0));
    hit(3);
    chk(8'h00, {7'h00, outq}, "queue");
    stop_test();
  end
endmodule : tb_top
